/* File: rtl/async_serial_transmitter.sv */
`timescale 1ns/100ps
`default_nettype none
module async_serial_transmitter
    import serial_tx_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic [4:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [4:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic TX_DATA_O,
    output logic TX_OE_O,
    output logic IRQ_O
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] tsc;
    logic [7:0] rsc;
    logic [7:0] bc;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [2:0] irq_ctl;
    tx_char_t hold;
    logic hold_full;
    logic [10:0] shifter;
    logic [3:0] bits_left;
    logic busy;
    logic flag_empty;
    logic flag_age;
    logic irq;
    logic tx_line;
    logic tx_oe;

    typedef enum {IDLE, SEND} tx_state_t;
    tx_state_t state;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake
    logic aw_held;
    logic w_held;
    logic [4:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic do_read;
    logic byte0;
    logic wr_tsc;
    logic wr_rsc;
    logic wr_bc;
    logic wr_dlo;
    logic wr_dhi;
    logic wr_hold;
    logic wr_ic;
    logic wr_known;
    logic rd_known;
    logic [7:0] rd_byte;

    function automatic logic rd_known_rd(input logic [4:0] a);
        rd_known_rd = (a == TX_STATUS_CONTROL_ADDR) || (a == RX_STATUS_CONTROL_ADDR)
            || (a == BAUD_CONTROL_ADDR) || (a == BAUD_DIVIDER_LOW_ADDR)
            || (a == BAUD_DIVIDER_HIGH_ADDR) || (a == TX_HOLDING_BUFFER_ADDR)
            || (a == IRQ_CONTROL_ADDR);
    endfunction

    assign do_write = aw_held && w_held && !S_AXI_BVALID_O;
    assign do_read = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    assign byte0 = w_strb[0];
    assign wr_tsc = do_write && byte0 && (aw_addr == TX_STATUS_CONTROL_ADDR);
    assign wr_rsc = do_write && byte0 && (aw_addr == RX_STATUS_CONTROL_ADDR);
    assign wr_bc = do_write && byte0 && (aw_addr == BAUD_CONTROL_ADDR);
    assign wr_dlo = do_write && byte0 && (aw_addr == BAUD_DIVIDER_LOW_ADDR);
    assign wr_dhi = do_write && byte0 && (aw_addr == BAUD_DIVIDER_HIGH_ADDR);
    assign wr_hold = do_write && byte0 && (aw_addr == TX_HOLDING_BUFFER_ADDR);
    assign wr_ic = do_write && byte0 && (aw_addr == IRQ_CONTROL_ADDR);
    assign wr_known = (aw_addr == TX_STATUS_CONTROL_ADDR) || (aw_addr == RX_STATUS_CONTROL_ADDR)
        || (aw_addr == BAUD_CONTROL_ADDR) || (aw_addr == BAUD_DIVIDER_LOW_ADDR)
        || (aw_addr == BAUD_DIVIDER_HIGH_ADDR) || (aw_addr == TX_HOLDING_BUFFER_ADDR)
        || (aw_addr == IRQ_CONTROL_ADDR);
    assign rd_known = rd_known_rd(S_AXI_ARADDR_I);

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 5'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR_I;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA_I;
                w_strb <= S_AXI_WSTRB_I;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= AXI_OKAY;
        end else begin
            S_AXI_AWREADY_O <= !aw_held && !(S_AXI_AWVALID_I && S_AXI_AWREADY_O) && !S_AXI_BVALID_O;
            S_AXI_WREADY_O <= !w_held && !(S_AXI_WVALID_I && S_AXI_WREADY_O) && !S_AXI_BVALID_O;
            if (do_write) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= wr_known ? AXI_OKAY : AXI_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // read mux; the buffer reads as zero, the shifter is never visible
    always_comb begin
        unique case (S_AXI_ARADDR_I)
            TX_STATUS_CONTROL_ADDR: rd_byte = tsc;
            RX_STATUS_CONTROL_ADDR: rd_byte = rsc;
            BAUD_CONTROL_ADDR: rd_byte = bc;
            BAUD_DIVIDER_LOW_ADDR: rd_byte = div_low;
            BAUD_DIVIDER_HIGH_ADDR: rd_byte = div_high;
            IRQ_CONTROL_ADDR: rd_byte = {4'h0, flag_empty, irq_ctl};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= AXI_OKAY;
        end else begin
            S_AXI_ARREADY_O <= !S_AXI_RVALID_O && !do_read;
            if (do_read) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O <= {24'h000000, rd_byte};
                S_AXI_RRESP_O <= rd_known ? AXI_OKAY : AXI_SLVERR;
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers; the shifter-empty bit is hardware owned
    logic enabled;
    logic load;
    logic tick;
    tx_config_t cfg;

    assign enabled = tsc[TSC_TX_ENABLE] && !tsc[TSC_CLOCKED_MODE] && rsc[RSC_PORT_ENABLE];
    assign cfg = '{enable: enabled, invert: bc[BC_POLARITY_INVERT], wide: bc[BC_WIDE_DIVIDER],
        high_speed: tsc[TSC_HIGH_SPEED], divider: {div_high, div_low}};

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            tsc <= TSC_RESET;
            rsc <= RSC_RESET;
            bc <= BC_RESET;
            div_low <= DIV_RESET;
            div_high <= DIV_RESET;
            irq_ctl <= IC_RESET[2:0];
        end else begin
            if (wr_tsc) begin
                tsc <= {w_data[7:2], !busy, w_data[0]};
            end else begin
                tsc[TSC_SHIFTER_EMPTY] <= !busy && !load;
            end
            if (wr_rsc) rsc <= w_data[7:0];
            if (wr_bc) bc <= w_data[7:0];
            if (wr_dlo) div_low <= w_data[7:0];
            if (wr_dhi) div_high <= w_data[7:0];
            if (wr_ic) irq_ctl <= w_data[2:0];
        end
    end

    baud_tick u_baud (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .run_i(busy),
        .cfg_i(cfg),
        .tick_o(tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // holding buffer and shifter
    assign load = enabled && hold_full && (state == IDLE);

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I || !enabled) begin
            hold <= '0;
            hold_full <= 1'b0;
        end else if (wr_hold) begin
            hold <= '{nine_bit: tsc[TSC_NINE_BIT], data: {tsc[TSC_NINTH_BIT], w_data[7:0]}};
            hold_full <= 1'b1;
        end else if (load) begin
            hold_full <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I || !enabled) begin
            state <= IDLE;
            busy <= 1'b0;
            shifter <= 11'h7ff;
            bits_left <= 4'h0;
        end else begin
            unique case (state)
                IDLE: begin
                    if (load) begin
                        state <= SEND;
                        busy <= 1'b1;
                        // start, data lsb first, stop; eight-bit frames fill the ninth slot with a stop
                        shifter <= hold.nine_bit ? {1'b1, hold.data, 1'b0}
                                                 : {2'b11, hold.data[7:0], 1'b0};
                        bits_left <= hold.nine_bit ? BITS_NINE : BITS_EIGHT;
                    end
                end
                SEND: begin
                    if (tick) begin
                        shifter <= {1'b1, shifter[10:1]};
                        bits_left <= bits_left - 4'h1;
                        if (bits_left == 4'h1) begin
                            state <= IDLE;
                            busy <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin and flags
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            tx_line <= 1'b1;
            tx_oe <= 1'b0;
        end else begin
            tx_line <= (state == SEND ? shifter[0] : 1'b1) ^ (cfg.invert && enabled);
            tx_oe <= enabled;
        end
    end

    // flag lags the write by two cycles, so a poll on the second cycle is valid
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            flag_age <= 1'b0;
            flag_empty <= 1'b0;
            irq <= 1'b0;
        end else begin
            flag_age <= enabled && !hold_full;
            flag_empty <= flag_age && enabled;
            irq <= flag_empty && irq_ctl[IC_TX_IRQ_ENABLE] && irq_ctl[IC_PERIPH_IRQ_ENABLE]
                && irq_ctl[IC_GLOBAL_IRQ_ENABLE];
        end
    end

    assign TX_DATA_O = tx_line;
    assign TX_OE_O = tx_oe;
    assign IRQ_O = irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_loaded;
        load ##1 (state == SEND);
    endsequence

    a_load_starts: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        load |=> (state == SEND) && !shifter[0]) else $error("load did not start a frame");
    a_idle_load: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (state == IDLE) && hold_full && enabled |=> (state == SEND)) else $error("idle shifter left buffer full");
    a_wait_busy: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (state == SEND) && hold_full && enabled |=> hold_full) else $error("buffer drained while busy");
    a_stop_reload: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        (state == SEND) && tick && (bits_left == 4'h1) && hold_full && enabled
        |=> load) else $error("pending char not loaded after stop");
    a_shift_empty: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        s_loaded |=> !tsc[TSC_SHIFTER_EMPTY]) else $error("shifter empty set while busy");
    a_flag_valid: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        enabled && !hold_full ##1 enabled && !hold_full |=> flag_empty) else $error("flag not valid");
    a_flag_tx_en: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        !enabled |=> ##1 !flag_empty) else $error("flag set while disabled");
    a_irq_gate: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        flag_empty && (irq_ctl == 3'h7) |=> irq) else $error("irq not raised");
    a_invert_idle: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
        enabled && (state == IDLE) ##1 $stable(bc) |-> TX_DATA_O == !bc[BC_POLARITY_INVERT])
        else $error("idle level wrong");
endmodule
`default_nettype wire

/* File: shared/serial_tx_pkg.sv */
package serial_tx_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [4:0] TX_STATUS_CONTROL_ADDR = 5'h00;
    localparam logic [4:0] RX_STATUS_CONTROL_ADDR = 5'h04;
    localparam logic [4:0] BAUD_CONTROL_ADDR = 5'h08;
    localparam logic [4:0] BAUD_DIVIDER_LOW_ADDR = 5'h0c;
    localparam logic [4:0] BAUD_DIVIDER_HIGH_ADDR = 5'h10;
    localparam logic [4:0] TX_HOLDING_BUFFER_ADDR = 5'h14;
    localparam logic [4:0] IRQ_CONTROL_ADDR = 5'h18;
    // transmit status and control fields
    localparam int TSC_NINTH_BIT = 0;
    localparam int TSC_SHIFTER_EMPTY = 1;
    localparam int TSC_HIGH_SPEED = 2;
    localparam int TSC_CLOCKED_MODE = 4;
    localparam int TSC_TX_ENABLE = 5;
    localparam int TSC_NINE_BIT = 6;
    // receive status and control fields
    localparam int RSC_PORT_ENABLE = 7;
    // baud control fields
    localparam int BC_WIDE_DIVIDER = 3;
    localparam int BC_POLARITY_INVERT = 4;
    // irq control fields
    localparam int IC_TX_IRQ_ENABLE = 0;
    localparam int IC_PERIPH_IRQ_ENABLE = 1;
    localparam int IC_GLOBAL_IRQ_ENABLE = 2;
    localparam int IC_BUFFER_EMPTY = 3;
    // reset values
    localparam logic [7:0] TSC_RESET = 8'h02;
    localparam logic [7:0] RSC_RESET = 8'h00;
    localparam logic [7:0] BC_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] IC_RESET = 8'h00;
    // frame timing and bus response codes
    localparam int FRAME_BITS_MAX = 11;
    localparam logic [3:0] BITS_EIGHT = 4'ha;
    localparam logic [3:0] BITS_NINE = 4'hb;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef struct packed {
        logic nine_bit;
        logic [8:0] data;
    } tx_char_t;

    typedef struct packed {
        logic enable;
        logic invert;
        logic wide;
        logic high_speed;
        logic [15:0] divider;
    } tx_config_t;
endpackage

/* File: rtl/baud_tick.sv */
`timescale 1ns/100ps
`default_nettype none
module baud_tick
    import serial_tx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire tx_config_t cfg_i,
    output logic tick_o
);
    // divider arrangement: 8-bit/16-bit divider, x64, x16 or x4 prescale
    logic [5:0] pre_count;
    logic [15:0] div_count;
    logic [5:0] pre_limit;
    logic pre_done;
    logic [15:0] div_limit;

    assign pre_limit = (cfg_i.wide && cfg_i.high_speed) ? 6'h03 :
                       (cfg_i.wide || cfg_i.high_speed) ? 6'h0f : 6'h3f;
    assign div_limit = cfg_i.wide ? cfg_i.divider : {8'h00, cfg_i.divider[7:0]};
    assign pre_done = (pre_count == pre_limit);
    // unregistered so the first bit of a frame is not a clock too long
    assign tick_o = pre_done && (div_count == div_limit);

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            pre_count <= 6'h00;
            div_count <= 16'h0000;
        end else begin
            pre_count <= pre_done ? 6'h00 : pre_count + 6'h01;
            if (pre_done) begin
                div_count <= (div_count == div_limit) ? 16'h0000 : div_count + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/serial_rx_model.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_rx_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic line_i,
    input wire logic invert_i,
    input wire logic nine_i,
    input wire logic [7:0] period_i,
    output logic [8:0] data_o,
    output logic [7:0] count_o,
    output logic [7:0] fault_o
);
    logic [8:0] shift;
    logic lvl;
    assign lvl = line_i ^ invert_i;
    initial begin
        data_o = 9'h000;
        count_o = 8'h00;
        fault_o = 8'h00;
        shift = 9'h000;
        forever begin
            @(posedge clk_i);
            // idle is mark, so a space level opens a frame
            if (run_i === 1'b1 && lvl === 1'b0) begin
                repeat (period_i / 2) @(posedge clk_i);
                if (lvl !== 1'b0) fault_o = fault_o + 8'h01;
                shift = 9'h000;
                for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
                    repeat (period_i) @(posedge clk_i);
                    shift[i] = lvl;
                end
                repeat (period_i) @(posedge clk_i);
                if (lvl !== 1'b1) fault_o = fault_o + 8'h01;
                // ninth bit kept as the address mark
                // non-blocking keeps the bench's reads free of races
                data_o <= shift;
                count_o <= count_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/test_async_serial_transmitter.sv */
`timescale 1ns/100ps
`default_nettype none
module test_async_serial_transmitter
    import serial_tx_pkg::*;
;
    // divider 1 with wide and high speed gives four clocks per count
    localparam logic [7:0] PERIOD = 8'h08;
    // eight-bit frame: start, eight data, one stop
    localparam int FRAME = 10 * PERIOD;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready, run, inv, nine;
    logic awready, wready, bvalid, arready, rvalid, txd, txoe, irq;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, resp;
    logic [8:0] rx_data;
    logic [7:0] rx_count, rx_fault;
    int num_errors, n_tests, cyc;

    async_serial_transmitter dut_u (.SYS_CLK_I(clk), .RESET_I(rst), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .TX_DATA_O(txd), .TX_OE_O(txoe), .IRQ_O(irq));
    serial_rx_model rx_u (.clk_i(clk), .run_i(run), .line_i(txd), .invert_i(inv), .nine_i(nine),
        .period_i(PERIOD), .data_o(rx_data), .count_o(rx_count), .fault_o(rx_fault));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic final_report;
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [4:0] a, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && t < 100);
        resp = bresp;
        bready <= 1'b0;
        check("write answered", t < 100, 1);
    endtask

    task automatic axi_rd(input logic [4:0] a);
        int t;
        t = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            t++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && t < 100);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        check("read answered", t < 100, 1);
    endtask

    task automatic rd_check(input string name, input logic [4:0] a, input logic [31:0] exp);
        axi_rd(a);
        check(name, rd, exp);
    endtask

    task automatic wait_rx(input logic [7:0] n, input logic [8:0] exp);
        int t;
        t = 0;
        while (rx_count < n && t < 3000) begin
            @(posedge clk);
            t++;
        end
        check("frame count", rx_count, n);
        check("frame data", rx_data, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        rd_check("tsc reset", TX_STATUS_CONTROL_ADDR, {24'h0, TSC_RESET});
        rd_check("rsc reset", RX_STATUS_CONTROL_ADDR, {24'h0, RSC_RESET});
        rd_check("bc reset", BAUD_CONTROL_ADDR, {24'h0, BC_RESET});
        rd_check("divl reset", BAUD_DIVIDER_LOW_ADDR, {24'h0, DIV_RESET});
        rd_check("divh reset", BAUD_DIVIDER_HIGH_ADDR, {24'h0, DIV_RESET});
        rd_check("ic reset", IRQ_CONTROL_ADDR, {24'h0, IC_RESET});
        rd_check("holding hidden", TX_HOLDING_BUFFER_ADDR, 32'h0);
        rd_check("unmapped data", 5'h1c, 32'h0);
        check("unmapped resp", resp, AXI_SLVERR);
        check("oe idle", txoe, 1'b0);
        check("line idle", txd, 1'b1);
    endtask

    task automatic t_enable;
        axi_wr(BAUD_DIVIDER_LOW_ADDR, 8'h01);
        check("write resp", resp, AXI_OKAY);
        axi_wr(BAUD_CONTROL_ADDR, 8'h08);
        axi_wr(RX_STATUS_CONTROL_ADDR, 8'h80);
        rd_check("flag before enable", IRQ_CONTROL_ADDR, 32'h00);
        axi_wr(TX_STATUS_CONTROL_ADDR, 8'h24);
        rd_check("flag after enable", IRQ_CONTROL_ADDR, 32'h08);
        check("oe enabled", txoe, 1'b1);
        check("line mark", txd, 1'b1);
        run <= 1'b1;
    endtask

    task automatic t_queue;
        int t0;
        axi_wr(TX_HOLDING_BUFFER_ADDR, 8'ha5);
        axi_wr(TX_HOLDING_BUFFER_ADDR, 8'h3c);
        rd_check("flag queued", IRQ_CONTROL_ADDR, 32'h00);
        rd_check("shifter busy", TX_STATUS_CONTROL_ADDR, 32'h24);
        wait_rx(8'd1, 9'h0a5);
        t0 = cyc;
        wait_rx(8'd2, 9'h03c);
        check("frame spacing", (cyc - t0 >= FRAME) && (cyc - t0 <= FRAME + 4), 1);
        repeat (2 * PERIOD) @(posedge clk);
        rd_check("shifter done", TX_STATUS_CONTROL_ADDR, 32'h26);
        rd_check("flag drained", IRQ_CONTROL_ADDR, 32'h08);
    endtask

    task automatic t_irq;
        axi_wr(IRQ_CONTROL_ADDR, 8'h06);
        repeat (2) @(posedge clk);
        check("irq masked", irq, 1'b0);
        rd_check("flag unmasked", IRQ_CONTROL_ADDR, 32'h0e);
        axi_wr(IRQ_CONTROL_ADDR, 8'h07);
        repeat (2) @(posedge clk);
        check("irq at once", irq, 1'b1);
        axi_wr(IRQ_CONTROL_ADDR, 8'h03);
        repeat (2) @(posedge clk);
        check("irq global off", irq, 1'b0);
        axi_wr(IRQ_CONTROL_ADDR, 8'h00);
        rd_check("flag read only", IRQ_CONTROL_ADDR, 32'h08);
    endtask

    task automatic t_invert;
        run <= 1'b0;
        axi_wr(BAUD_CONTROL_ADDR, 8'h18);
        inv <= 1'b1;
        repeat (4) @(posedge clk);
        check("inverted idle", txd, 1'b0);
        run <= 1'b1;
        axi_wr(TX_HOLDING_BUFFER_ADDR, 8'h81);
        wait_rx(8'd3, 9'h081);
        repeat (2 * PERIOD) @(posedge clk);
        run <= 1'b0;
        axi_wr(BAUD_CONTROL_ADDR, 8'h08);
        inv <= 1'b0;
        repeat (4) @(posedge clk);
        run <= 1'b1;
    endtask

    task automatic t_nine;
        nine <= 1'b1;
        axi_wr(TX_STATUS_CONTROL_ADDR, 8'h65);
        axi_wr(TX_HOLDING_BUFFER_ADDR, 8'h5a);
        axi_wr(TX_STATUS_CONTROL_ADDR, 8'h64);
        wait_rx(8'd4, 9'h15a);
        repeat (2 * PERIOD) @(posedge clk);
        axi_wr(TX_HOLDING_BUFFER_ADDR, 8'h3c);
        wait_rx(8'd5, 9'h03c);
        repeat (2 * PERIOD) @(posedge clk);
        axi_wr(TX_STATUS_CONTROL_ADDR, 8'h24);
        nine <= 1'b0;
    endtask

    task automatic t_gated;
        axi_wr(TX_STATUS_CONTROL_ADDR, 8'h34);
        axi_wr(TX_HOLDING_BUFFER_ADDR, 8'h55);
        repeat (2 * FRAME) @(posedge clk);
        check("clocked mode silent", rx_count, 8'd5);
        axi_wr(TX_STATUS_CONTROL_ADDR, 8'h00);
        axi_wr(RX_STATUS_CONTROL_ADDR, 8'h00);
        axi_wr(TX_STATUS_CONTROL_ADDR, 8'h24);
        axi_wr(TX_HOLDING_BUFFER_ADDR, 8'h55);
        repeat (2 * FRAME) @(posedge clk);
        check("port off silent", rx_count, 8'd5);
        check("line faults", rx_fault, 8'd0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, run, inv, nine} = 9'h100;
        awaddr = 5'h00;
        araddr = 5'h00;
        wdata = 32'h0;
        num_errors = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_enable();
        t_queue();
        t_irq();
        t_invert();
        t_nine();
        t_gated();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
